// ==== pkg/panel_pkg.sv ====
// constants, encodings and carrier types for the panel command decoder
package panel_pkg;

  // register port offsets
  localparam logic [3:0] OFS_CMD = 4'h0;
  localparam logic [3:0] OFS_DATA = 4'h1;
  localparam logic [3:0] OFS_CONTRAST = 4'h2;
  localparam logic [3:0] OFS_START_LINE = 4'h3;
  localparam logic [3:0] OFS_MUX = 4'h4;
  localparam logic [3:0] OFS_OFFSET = 4'h5;
  localparam logic [3:0] OFS_CLOCK = 4'h6;
  localparam logic [3:0] OFS_GPIO = 4'h7;
  localparam logic [3:0] OFS_SCROLL = 4'h8;

  // status bit positions
  localparam int STAT_LOCKED = 0;
  localparam int STAT_SCROLL = 1;
  localparam int STAT_OFF = 6;

  // command codes
  localparam logic [7:0] CMD_START_LO = 8'h40;
  localparam logic [7:0] CMD_START_HI = 8'h7F;
  localparam logic [7:0] CMD_CONTRAST = 8'h81;
  localparam logic [7:0] CMD_REMAP_OFF = 8'hA0;
  localparam logic [7:0] CMD_REMAP_ON = 8'hA1;
  localparam logic [7:0] CMD_FOLLOW_RAM = 8'hA4;
  localparam logic [7:0] CMD_ALL_ON = 8'hA5;
  localparam logic [7:0] CMD_NORMAL = 8'hA6;
  localparam logic [7:0] CMD_INVERSE = 8'hA7;
  localparam logic [7:0] CMD_MUX = 8'hA8;
  localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
  localparam logic [7:0] CMD_DISP_ON = 8'hAF;
  localparam logic [7:0] CMD_PAGE_LO = 8'hB0;
  localparam logic [7:0] CMD_PAGE_HI = 8'hB7;
  localparam logic [7:0] CMD_SCAN_UP = 8'hC0;
  localparam logic [7:0] CMD_SCAN_DOWN = 8'hC8;
  localparam logic [7:0] CMD_OFFSET = 8'hD3;
  localparam logic [7:0] CMD_CLOCK = 8'hD5;
  localparam logic [7:0] CMD_PRECHARGE = 8'hD9;
  localparam logic [7:0] CMD_COM_PINS = 8'hDA;
  localparam logic [7:0] CMD_DESELECT = 8'hDB;
  localparam logic [7:0] CMD_GPIO = 8'hDC;
  localparam logic [7:0] CMD_LOCK = 8'hFD;
  localparam logic [7:0] CMD_HSCROLL_R = 8'h26;
  localparam logic [7:0] CMD_HSCROLL_L = 8'h27;
  localparam logic [7:0] CMD_VHSCROLL_R = 8'h29;
  localparam logic [7:0] CMD_VHSCROLL_L = 8'h2A;
  localparam logic [7:0] CMD_CONTENT_R = 8'h2C;
  localparam logic [7:0] CMD_CONTENT_L = 8'h2D;
  localparam logic [7:0] CMD_SCROLL_STOP = 8'h2E;
  localparam logic [7:0] CMD_SCROLL_GO = 8'h2F;
  localparam logic [7:0] CMD_ADDR_MODE = 8'h20;
  localparam logic [7:0] CMD_COL_ADDR = 8'h21;
  localparam logic [7:0] CMD_PAGE_ADDR = 8'h22;
  localparam logic [7:0] CMD_VSCROLL_AREA = 8'hA3;

  // parameter byte counts
  localparam logic [2:0] PCNT_NONE = 3'h0;
  localparam logic [2:0] PCNT_ONE = 3'h1;
  localparam logic [2:0] PCNT_TWO = 3'h2;
  localparam logic [2:0] PCNT_SCROLL = 3'h7;
  localparam int PARAM_DEPTH = 7;

  // field positions and limits
  localparam int LOCK_BIT = 2;
  localparam int COM_ALT_BIT = 4;
  localparam int COM_LR_BIT = 5;
  localparam logic [5:0] MUX_MIN_CODE = 6'h0F;

  // reset values
  localparam logic [7:0] RST_CONTRAST = 8'h7F;
  localparam logic [5:0] RST_MUX = 6'h3F;
  localparam logic [3:0] RST_CLK_DIV = 4'h0;
  localparam logic [3:0] RST_OSC = 4'h8;
  localparam logic [7:0] RST_PRECHARGE = 8'h22;
  localparam logic [7:0] RST_GPIO = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PARAM = 2'b10
  } dec_state_t;

  typedef struct packed {
    logic [5:0] start_line;
    logic [7:0] contrast;
    logic seg_remap;
    logic entire_on;
    logic inverse;
    logic [5:0] mux_ratio;
    logic display_on;
    logic [2:0] page_start;
    logic com_reverse;
    logic [5:0] offset;
    logic [3:0] clk_div;
    logic [3:0] osc_freq;
    logic [7:0] precharge;
    logic com_alt;
    logic com_lr_swap;
    logic [7:0] gpio;
    logic locked;
  } panel_cfg_t;

  typedef struct packed {
    logic horiz_on;
    logic vert_on;
    logic dir_left;
    logic [2:0] start_page;
    logic [2:0] interval;
    logic [2:0] end_page;
    logic [5:0] voffset;
    logic [6:0] start_col;
    logic [6:0] end_col;
  } scroll_cfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic seg_remap;
  } mem_write_t;

endpackage

// ==== src/oled_panel_command_decoder.sv ====
// command decoder, scan timing and scroll engine of the panel controller
//
// Contract
// - 40h-7Fh load start line 0..63
// - 81h loads 8-bit contrast value
// - A0h/A1h remap only affects later writes; the code also mirrors MEM_COLUMN at once
// - A5h all pixels on, A4h follow memory
// - A6h normal, A7h inverse pixel polarity
// - A8h sets multiplex ratio 16..64
// - AEh off: segments ground, commons floating
// - B0h-B7h set page start pointer
// - C0h/C8h scan direction flips image immediately
// - D3h sets 6-bit common offset
// - D5h low nibble divides display clock
// - D5h high nibble selects oscillator setting
// - D9h pre-charge length, reset two clocks
// - DAh bit4 alternative, bit5 left/right swap
// - DCh parameter sets general-purpose pin
// - FDh bit2 locks, ignores other traffic
// - horizontal scroll rotates 128 columns
// - offsets choose horizontal, vertical or diagonal
// - 2Eh stops scroll; host rewrites memory
// - 2Fh starts using latest setup only
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module oled_panel_command_decoder (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // display memory write
  output panel_pkg::mem_write_t MEM_WRITE,
  // scan side
  input wire logic CLOCK_SOURCE_SELECT_PIN,
  input wire logic PIXEL_IN,
  input wire logic [6:0] COLUMN_IN,
  output logic PIXEL_OUT,
  output logic [6:0] MEM_COLUMN,
  output logic [5:0] MEM_ROW,
  output logic [5:0] COM_INDEX,
  output logic DISPLAY_CLOCK_TICK,
  output logic FRAME_START,
  output logic SEGMENT_OUTPUT_EN,
  output logic COM_OE,
  output logic OSC_ENABLE,
  // configuration
  output panel_pkg::panel_cfg_t CFG,
  output panel_pkg::scroll_cfg_t SCROLL_CFG,
  output logic SCROLL_ACTIVE,
  output logic [6:0] HSCROLL,
  output logic [5:0] VSCROLL
);
  import panel_pkg::*;

  // number of parameter bytes that follow a command
  function automatic logic [2:0] param_count(input logic [7:0] c);
    case (c)
      CMD_CONTRAST, CMD_MUX, CMD_OFFSET, CMD_CLOCK, CMD_PRECHARGE,
      CMD_COM_PINS, CMD_DESELECT, CMD_GPIO, CMD_LOCK, CMD_ADDR_MODE: param_count = PCNT_ONE;
      CMD_COL_ADDR, CMD_PAGE_ADDR, CMD_VSCROLL_AREA: param_count = PCNT_TWO;
      CMD_HSCROLL_R, CMD_HSCROLL_L, CMD_VHSCROLL_R, CMD_VHSCROLL_L,
      CMD_CONTENT_R, CMD_CONTENT_L: param_count = PCNT_SCROLL;
      default: param_count = PCNT_NONE;
    endcase
  endfunction

  function automatic logic is_scroll_setup(input logic [7:0] c);
    is_scroll_setup = (c == CMD_HSCROLL_R) || (c == CMD_HSCROLL_L) ||
                      (c == CMD_VHSCROLL_R) || (c == CMD_VHSCROLL_L);
  endfunction

  dec_state_t state_reg;
  logic [7:0] cmd_reg;
  logic [2:0] idx_reg;
  logic [2:0] need_reg;
  logic done_reg;
  logic [7:0] param_reg [PARAM_DEPTH];
  panel_cfg_t cfg_reg;
  scroll_cfg_t scroll_reg;
  logic scroll_active_reg;
  logic [6:0] hscroll_reg;
  logic [5:0] vscroll_reg;
  logic [2:0] frame_cnt_reg;
  logic [3:0] div_cnt_reg;
  logic tick_reg;
  logic [5:0] row_reg;
  logic frame_reg;
  logic [7:0] rdata_reg;
  mem_write_t mem_reg;
  logic pixel_reg;
  logic [6:0] column_reg;
  logic [5:0] mem_row_reg;
  logic [5:0] com_reg;

  logic cmd_wr;
  logic data_wr;
  logic single_ok;
  logic [2:0] cnt_in;
  logic [6:0] seg_col;

  assign cmd_wr = WR && (ADDR == OFS_CMD);
  assign data_wr = WR && (ADDR == OFS_DATA);
  assign cnt_in = param_count(WDATA);
  // while locked only the lock command itself gets through
  assign single_ok = cmd_wr && (state_reg == ST_IDLE) && !cfg_reg.locked;

  // byte collection; the setting lands one cycle after its last byte
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 8'h00;
      idx_reg <= 3'h0;
      need_reg <= 3'h0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (cmd_wr && (cnt_in != PCNT_NONE) &&
              (!cfg_reg.locked || WDATA == CMD_LOCK)) begin
            state_reg <= ST_PARAM;
            cmd_reg <= WDATA;
            idx_reg <= 3'h0;
            need_reg <= cnt_in - 3'h1;
          end
        end
        ST_PARAM: begin
          if (cmd_wr) begin
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == need_reg) begin
              state_reg <= ST_IDLE;
              done_reg <= 1'b1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PARAM_DEPTH; gi++) begin : g_param
      always_ff @(posedge CLOCK) begin
        if (RST) begin
          param_reg[gi] <= 8'h00;
        end else if (cmd_wr && state_reg == ST_PARAM && idx_reg == 3'(gi)) begin
          param_reg[gi] <= WDATA;
        end
      end
    end
  endgenerate

  // panel settings
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cfg_reg <= '0;
      cfg_reg.contrast <= RST_CONTRAST;
      cfg_reg.mux_ratio <= RST_MUX;
      cfg_reg.clk_div <= RST_CLK_DIV;
      cfg_reg.osc_freq <= RST_OSC;
      cfg_reg.precharge <= RST_PRECHARGE;
      cfg_reg.gpio <= RST_GPIO;
    end else begin
      if (done_reg) begin
        case (cmd_reg)
          CMD_CONTRAST: cfg_reg.contrast <= param_reg[0];
          CMD_MUX: begin
            // codes below 15 are not a legal ratio and leave it unchanged
            if (param_reg[0][5:0] >= MUX_MIN_CODE) begin
              cfg_reg.mux_ratio <= param_reg[0][5:0];
            end
          end
          CMD_OFFSET: cfg_reg.offset <= param_reg[0][5:0];
          CMD_CLOCK: begin
            cfg_reg.clk_div <= param_reg[0][3:0];
            cfg_reg.osc_freq <= param_reg[0][7:4];
          end
          CMD_PRECHARGE: cfg_reg.precharge <= param_reg[0];
          CMD_COM_PINS: begin
            cfg_reg.com_alt <= param_reg[0][COM_ALT_BIT];
            cfg_reg.com_lr_swap <= param_reg[0][COM_LR_BIT];
          end
          CMD_GPIO: cfg_reg.gpio <= param_reg[0];
          CMD_LOCK: cfg_reg.locked <= param_reg[0][LOCK_BIT];
          default: ;
        endcase
      end
      if (single_ok) begin
        if (WDATA >= CMD_START_LO && WDATA <= CMD_START_HI) begin
          cfg_reg.start_line <= WDATA[5:0];
        end
        if (WDATA >= CMD_PAGE_LO && WDATA <= CMD_PAGE_HI) begin
          cfg_reg.page_start <= WDATA[2:0];
        end
        case (WDATA)
          CMD_REMAP_OFF: cfg_reg.seg_remap <= 1'b0;
          CMD_REMAP_ON: cfg_reg.seg_remap <= 1'b1;
          CMD_FOLLOW_RAM: cfg_reg.entire_on <= 1'b0;
          CMD_ALL_ON: cfg_reg.entire_on <= 1'b1;
          CMD_NORMAL: cfg_reg.inverse <= 1'b0;
          CMD_INVERSE: cfg_reg.inverse <= 1'b1;
          CMD_DISP_OFF: cfg_reg.display_on <= 1'b0;
          CMD_DISP_ON: cfg_reg.display_on <= 1'b1;
          CMD_SCAN_UP: cfg_reg.com_reverse <= 1'b0;
          CMD_SCAN_DOWN: cfg_reg.com_reverse <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // scroll setup: a new setup replaces every field of the old one
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      scroll_reg <= '0;
    end else if (done_reg && is_scroll_setup(cmd_reg)) begin
      scroll_reg.start_page <= param_reg[1][2:0];
      scroll_reg.interval <= param_reg[2][2:0];
      scroll_reg.end_page <= param_reg[3][2:0];
      scroll_reg.start_col <= param_reg[5][6:0];
      scroll_reg.end_col <= param_reg[6][6:0];
      scroll_reg.dir_left <= (cmd_reg == CMD_HSCROLL_L) || (cmd_reg == CMD_VHSCROLL_L);
      if (cmd_reg == CMD_HSCROLL_R || cmd_reg == CMD_HSCROLL_L) begin
        scroll_reg.horiz_on <= 1'b1;
        scroll_reg.vert_on <= 1'b0;
        scroll_reg.voffset <= 6'h00;
      end else begin
        scroll_reg.horiz_on <= param_reg[0][0];
        scroll_reg.vert_on <= (param_reg[4][5:0] != 6'h00);
        scroll_reg.voffset <= param_reg[4][5:0];
      end
    end
  end

  // scroll motion, stepped once every interval+1 frames
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      scroll_active_reg <= 1'b0;
      hscroll_reg <= 7'h00;
      vscroll_reg <= 6'h00;
      frame_cnt_reg <= 3'h0;
    end else if (single_ok && WDATA == CMD_SCROLL_STOP) begin
      // the offsets are dropped, so memory shows unscrolled and must be rewritten
      scroll_active_reg <= 1'b0;
      hscroll_reg <= 7'h00;
      vscroll_reg <= 6'h00;
      frame_cnt_reg <= 3'h0;
    end else if (single_ok && WDATA == CMD_SCROLL_GO) begin
      scroll_active_reg <= 1'b1;
      frame_cnt_reg <= 3'h0;
    end else if (scroll_active_reg && frame_reg) begin
      if (frame_cnt_reg == scroll_reg.interval) begin
        frame_cnt_reg <= 3'h0;
        if (scroll_reg.horiz_on) begin
          // seven bits wrap the edge column to the far side
          hscroll_reg <= scroll_reg.dir_left ? hscroll_reg + 7'h01 : hscroll_reg - 7'h01;
        end
        if (scroll_reg.vert_on) begin
          vscroll_reg <= vscroll_reg + scroll_reg.voffset;
        end
      end else begin
        frame_cnt_reg <= frame_cnt_reg + 3'h1;
      end
    end
  end

  // display clock divider: field value plus one
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      div_cnt_reg <= 4'h0;
      tick_reg <= 1'b0;
    end else if (div_cnt_reg >= cfg_reg.clk_div) begin
      div_cnt_reg <= 4'h0;
      tick_reg <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 4'h1;
      tick_reg <= 1'b0;
    end
  end

  // common scan, one row per display clock
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      row_reg <= 6'h00;
      frame_reg <= 1'b0;
      com_reg <= 6'h00;
      mem_row_reg <= 6'h00;
    end else begin
      frame_reg <= 1'b0;
      if (tick_reg) begin
        if (row_reg >= cfg_reg.mux_ratio) begin
          row_reg <= 6'h00;
          frame_reg <= 1'b1;
        end else begin
          row_reg <= row_reg + 6'h01;
        end
        com_reg <= cfg_reg.com_reverse ? cfg_reg.mux_ratio - row_reg : row_reg;
        mem_row_reg <= row_reg + cfg_reg.start_line + cfg_reg.offset + vscroll_reg;
      end
    end
  end

  // segment path: one cycle from pixel in to pixel out
  assign seg_col = cfg_reg.seg_remap ? ~COLUMN_IN : COLUMN_IN;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pixel_reg <= 1'b0;
      column_reg <= 7'h00;
    end else begin
      pixel_reg <= cfg_reg.display_on &&
                   (cfg_reg.entire_on || (PIXEL_IN ^ cfg_reg.inverse));
      column_reg <= seg_col + hscroll_reg;
    end
  end

  // memory writes carry the remap in force when they arrive
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mem_reg <= '0;
    end else begin
      mem_reg.valid <= data_wr && !cfg_reg.locked;
      mem_reg.data <= WDATA;
      mem_reg.seg_remap <= cfg_reg.seg_remap;
    end
  end

  // register read, data stands only in the cycle after the strobe
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_reg <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        OFS_CMD: begin
          rdata_reg <= 8'h00;
          rdata_reg[STAT_OFF] <= !cfg_reg.display_on;
          rdata_reg[STAT_LOCKED] <= cfg_reg.locked;
          rdata_reg[STAT_SCROLL] <= scroll_active_reg;
        end
        OFS_CONTRAST: rdata_reg <= cfg_reg.contrast;
        OFS_START_LINE: rdata_reg <= {2'b00, cfg_reg.start_line};
        OFS_MUX: rdata_reg <= {2'b00, cfg_reg.mux_ratio};
        OFS_OFFSET: rdata_reg <= {2'b00, cfg_reg.offset};
        OFS_CLOCK: rdata_reg <= {cfg_reg.osc_freq, cfg_reg.clk_div};
        OFS_GPIO: rdata_reg <= cfg_reg.gpio;
        OFS_SCROLL: rdata_reg <= {1'b0, hscroll_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign RDATA = rdata_reg;
  assign MEM_WRITE = mem_reg;
  assign PIXEL_OUT = pixel_reg;
  assign MEM_COLUMN = column_reg;
  assign MEM_ROW = mem_row_reg;
  assign COM_INDEX = com_reg;
  assign DISPLAY_CLOCK_TICK = tick_reg;
  assign FRAME_START = frame_reg;
  // off: segments held at ground, commons released
  assign SEGMENT_OUTPUT_EN = cfg_reg.display_on;
  assign COM_OE = cfg_reg.display_on;
  assign OSC_ENABLE = CLOCK_SOURCE_SELECT_PIN;
  assign CFG = cfg_reg;
  assign SCROLL_CFG = scroll_reg;
  assign SCROLL_ACTIVE = scroll_active_reg;
  assign HSCROLL = hscroll_reg;
  assign VSCROLL = vscroll_reg;

endmodule // oled_panel_command_decoder

`default_nettype wire

// ==== tb/panel_props.sv ====
// assertion checker for the panel command decoder ports
`timescale 1ns/1ps
`default_nettype none
module panel_props (
  // clock, reset and register port
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  // design outputs and scan inputs
  input wire panel_pkg::mem_write_t MEM_WRITE,
  input wire logic CLOCK_SOURCE_SELECT_PIN,
  input wire logic PIXEL_IN,
  input wire logic PIXEL_OUT,
  input wire logic DISPLAY_CLOCK_TICK,
  input wire logic SEGMENT_OUTPUT_EN,
  input wire logic COM_OE,
  input wire logic OSC_ENABLE,
  input wire panel_pkg::panel_cfg_t CFG,
  input wire panel_pkg::scroll_cfg_t SCROLL_CFG,
  input wire logic SCROLL_ACTIVE,
  input wire logic [6:0] HSCROLL
);
  import panel_pkg::*;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  logic [2:0] pend_reg;
  logic cmd_wr;
  logic go;
  assign cmd_wr = WR && ADDR == OFS_CMD;
  assign go = cmd_wr && pend_reg == 3'h0 && !CFG.locked;
  // parameter bytes must never be taken for command bytes
  function automatic logic [2:0] plen(input logic [7:0] c);
    case (c)
      8'h21, 8'h22, 8'hA3: plen = 3'h2;
      8'h26, 8'h27, 8'h29, 8'h2A, 8'h2C, 8'h2D: plen = 3'h7;
      8'h20, 8'h81, 8'hA8, 8'hD3, 8'hD5, 8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hFD: plen = 3'h1;
      default: plen = 3'h0;
    endcase
  endfunction
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pend_reg <= 3'h0;
    end else if (cmd_wr) begin
      pend_reg <= (pend_reg == 3'h0) ? plen(WDATA) : pend_reg - 3'h1;
    end
  end
  sequence s_param(logic [7:0] c);
    go && WDATA == c ##1 !cmd_wr ##1 cmd_wr;
  endsequence
  property p_start;
    go && WDATA[7:6] == 2'b01 |=> CFG.start_line == $past(WDATA[5:0]);
  endproperty
  a_start: assert property (p_start) else $error("start line wrong");
  property p_contrast;
    s_param(CMD_CONTRAST) |-> ##2 CFG.contrast == $past(WDATA, 2);
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast wrong");
  property p_scan;
    go && (WDATA == CMD_SCAN_UP || WDATA == CMD_SCAN_DOWN) |=> CFG.com_reverse == $past(WDATA[3]);
  endproperty
  a_scan: assert property (p_scan) else $error("scan direction wrong");
  property p_pixel;
    1'b1 |=> PIXEL_OUT == $past(CFG.display_on && (CFG.entire_on || (PIXEL_IN ^ CFG.inverse)));
  endproperty
  a_pixel: assert property (p_pixel) else $error("pixel wrong");
  property p_drive;
    SEGMENT_OUTPUT_EN == CFG.display_on && COM_OE == CFG.display_on;
  endproperty
  a_drive: assert property (p_drive) else $error("output drive wrong");
  property p_osc;
    OSC_ENABLE == CLOCK_SOURCE_SELECT_PIN;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable wrong");
  property p_tick;
    DISPLAY_CLOCK_TICK && CFG.clk_div == 4'h3 |=> !DISPLAY_CLOCK_TICK [*3] ##1 DISPLAY_CLOCK_TICK;
  endproperty
  a_tick: assert property (p_tick) else $error("tick spacing wrong");
  property p_mem;
    !CFG.locked && WR && ADDR == OFS_DATA |=> MEM_WRITE.valid && MEM_WRITE.data == $past(WDATA)
      && MEM_WRITE.seg_remap == $past(CFG.seg_remap);
  endproperty
  a_mem: assert property (p_mem) else $error("memory write wrong");
  property p_lock;
    CFG.locked && WR && ADDR == OFS_DATA |=> !MEM_WRITE.valid;
  endproperty
  a_lock: assert property (p_lock) else $error("write passed lock");
  property p_go;
    go && WDATA == CMD_SCROLL_GO |=> SCROLL_ACTIVE;
  endproperty
  a_go: assert property (p_go) else $error("scroll not started");
  property p_stop;
    go && WDATA == CMD_SCROLL_STOP |=> !SCROLL_ACTIVE && HSCROLL == 7'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("scroll not stopped");
  property p_hstep;
    SCROLL_ACTIVE && $past(SCROLL_ACTIVE) && HSCROLL != $past(HSCROLL) |->
      HSCROLL == (SCROLL_CFG.dir_left ? $past(HSCROLL) + 7'h01 : $past(HSCROLL) - 7'h01);
  endproperty
  a_hstep: assert property (p_hstep) else $error("scroll step wrong");
endmodule // panel_props
bind oled_panel_command_decoder panel_props props (
  .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .MEM_WRITE(MEM_WRITE),
  .CLOCK_SOURCE_SELECT_PIN(CLOCK_SOURCE_SELECT_PIN), .PIXEL_IN(PIXEL_IN),
  .PIXEL_OUT(PIXEL_OUT), .DISPLAY_CLOCK_TICK(DISPLAY_CLOCK_TICK), .COM_OE(COM_OE),
  .SEGMENT_OUTPUT_EN(SEGMENT_OUTPUT_EN), .OSC_ENABLE(OSC_ENABLE), .CFG(CFG),
  .SCROLL_CFG(SCROLL_CFG), .SCROLL_ACTIVE(SCROLL_ACTIVE), .HSCROLL(HSCROLL)
);
`default_nettype wire

// ==== tb/host_model.sv ====
// host side model driving the decoder register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic CLOCK,
  // register port
  output var logic [3:0] ADDR,
  output var logic [7:0] WDATA,
  output var logic WR,
  output var logic RD,
  input wire logic [7:0] RDATA
);
  import panel_pkg::*;
  logic scroll_on = 1'b0;
  logic [7:0] p [7];
  initial begin
    ADDR = 4'h0;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
  end
  // released data is inverted so a stale byte is never mistaken for a fresh one
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
    WDATA <= ~d;
    @(posedge CLOCK);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    @(posedge CLOCK);
    d = RDATA;
  endtask
  task automatic cmd2(input logic [7:0] c, input logic [7:0] v);
    wr(OFS_CMD, c);
    wr(OFS_CMD, v);
  endtask
  task automatic stop();
    wr(OFS_CMD, CMD_SCROLL_STOP);
    scroll_on = 1'b0;
  endtask
  task automatic go();
    wr(OFS_CMD, CMD_SCROLL_GO);
    scroll_on = 1'b1;
  endtask
  task automatic setup(input logic [7:0] c, input logic [7:0] a, input logic [7:0] e);
    if (scroll_on) begin
      stop();
    end
    wr(OFS_CMD, c);
    p = '{a, 8'h00, 8'h00, 8'h00, e, 8'h00, 8'h7F};
    foreach (p[i]) wr(OFS_CMD, p[i]);
  endtask
  task automatic data(input logic [7:0] d);
    if (scroll_on) begin
      stop();
    end
    wr(OFS_DATA, d);
  endtask
endmodule // host_model
`default_nettype wire

// ==== tb/test_oled_panel_command_decoder.sv ====
// self-checking bench for the panel command decoder
`timescale 1ns/1ps
`default_nettype none
module test_oled_panel_command_decoder;
  import panel_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic csel = 1'b0;
  logic pixel_in = 1'b0;
  logic [6:0] column_in = 7'h00;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic wr, rd;
  logic [4:0] flags = 5'h00;
  mem_write_t mem_write;
  panel_cfg_t cfg;
  scroll_cfg_t scroll_cfg;
  logic scroll_active, pixel_out, tick, frame_start, seg_en, com_oe, osc_en;
  logic [6:0] mem_column, hscroll, col_q;
  logic [5:0] mem_row, com_index, vscroll;
  int miscompares = 0;
  int check_count = 0;
  int m[int];
  int r;
  int n;
  logic [7:0] codes [10] = '{8'hA1, 8'hA5, 8'hA7, 8'hAF, 8'hC8, 8'hA0, 8'hA4, 8'hA6, 8'hAE, 8'hC0};
  logic [7:0] pc [6] = '{8'h81, 8'hD3, 8'hD5, 8'hDC, 8'hA8, 8'hA8};
  logic [7:0] pm [6] = '{8'hFF, 8'h3F, 8'hFC, 8'hFF, 8'h3F, 8'h07};
  logic [3:0] po [6] = '{4'h2, 4'h5, 4'h6, 4'h7, 4'h4, 4'h4};
  logic [7:0] sc [3] = '{8'h29, 8'h27, 8'h29};
  logic [7:0] sa [3] = '{8'h01, 8'h00, 8'h00};
  logic [7:0] se [3] = '{8'h01, 8'h00, 8'h02};
  logic [7:0] sh [3] = '{8'h7F, 8'h01, 8'h00};
  logic [7:0] sv [3] = '{8'h01, 8'h00, 8'h02};
  always #4 clock = ~clock;
  always @(posedge clock) begin
    csel <= 1'($urandom);
    pixel_in <= 1'($urandom);
    column_in <= 7'($urandom);
    col_q <= column_in;
  end
  host_model host (.CLOCK(clock), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
  oled_panel_command_decoder uut (
    .CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .MEM_WRITE(mem_write), .CLOCK_SOURCE_SELECT_PIN(csel), .PIXEL_IN(pixel_in),
    .COLUMN_IN(column_in), .PIXEL_OUT(pixel_out), .MEM_COLUMN(mem_column), .MEM_ROW(mem_row),
    .COM_INDEX(com_index), .DISPLAY_CLOCK_TICK(tick), .FRAME_START(frame_start),
    .SEGMENT_OUTPUT_EN(seg_en), .COM_OE(com_oe), .OSC_ENABLE(osc_en), .CFG(cfg),
    .SCROLL_CFG(scroll_cfg), .SCROLL_ACTIVE(scroll_active), .HSCROLL(hscroll), .VSCROLL(vscroll)
  );
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_reg(input logic [3:0] a);
    host.rd(a, rv);
    chk($sformatf("reg %h", a), 8'(m[a]), rv);
  endtask
  task automatic final_report();
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under ten thousand cycles
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  initial begin
    void'($urandom(34));
    m = '{0: 8'h40, 2: 8'h7F, 3: 0, 4: 8'h3F, 5: 0, 6: 8'h80, 7: 0, 8: 0, 9: 0, 15: 0};
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    foreach (m[a]) chk_reg(4'(a));
    chk("precharge", 8'h22, cfg.precharge);
    for (int i = 0; i < 10; i++) begin
      host.wr(OFS_CMD, codes[i]);
      flags[4 - i % 5] = (i < 5);
      chk("flags", {3'h0, flags}, {3'h0, cfg.seg_remap, cfg.entire_on, cfg.inverse,
        cfg.display_on, cfg.com_reverse});
    end
    r = $urandom % 64;
    host.wr(OFS_CMD, 8'(CMD_START_LO + r));
    m[OFS_START_LINE] = r;
    chk_reg(OFS_START_LINE);
    r = $urandom % 8;
    host.wr(OFS_CMD, 8'(CMD_PAGE_LO + r));
    chk("page", 8'(r), {5'h00, cfg.page_start});
    for (int i = 0; i < 6; i++) begin
      r = $urandom & pm[i];
      host.wr(OFS_CMD, pc[i]);
      chk_reg(po[i]);
      host.wr(OFS_CMD, 8'(r));
      if (pc[i] != CMD_MUX || r >= 15) m[po[i]] = r;
      chk_reg(po[i]);
    end
    host.cmd2(CMD_PRECHARGE, 8'hF1);
    host.cmd2(CMD_COM_PINS, 8'h20);
    @(posedge clock);
    chk("precharge", 8'hF1, cfg.precharge);
    chk("com pins", 8'h02, {6'h00, cfg.com_lr_swap, cfg.com_alt});
    host.data(8'h5A);
    host.cmd2(CMD_LOCK, 8'h16);
    m[OFS_CMD] = 8'h41;
    chk_reg(OFS_CMD);
    host.wr(OFS_CMD, CMD_DISP_ON);
    host.data(8'hA5);
    chk_reg(OFS_CMD);
    host.cmd2(CMD_LOCK, 8'h12);
    m[OFS_CMD] = 8'h40;
    chk_reg(OFS_CMD);
    // a short frame keeps each scroll step within a few dozen cycles
    host.cmd2(CMD_MUX, 8'h0F);
    host.cmd2(CMD_CLOCK, 8'h80);
    for (int i = 0; i < 3; i++) begin
      host.setup(sc[i], sa[i], se[i]);
      host.go();
      n = 0;
      while (hscroll === 7'h00 && vscroll === 6'h00 && n < 500) begin
        @(posedge clock);
        n++;
      end
      // one more edge so the column path has taken up the new offset
      @(posedge clock);
      chk("hscroll", sh[i], {1'b0, hscroll});
      chk("vscroll", sv[i], {2'b00, vscroll});
      chk("column", {1'b0, 7'(col_q + sh[i][6:0])}, {1'b0, mem_column});
    end
    host.stop();
    chk_reg(OFS_SCROLL);
    host.data(8'h00);
    host.cmd2(CMD_CLOCK, 8'h53);
    m[OFS_CLOCK] = 8'h53;
    chk_reg(OFS_CLOCK);
    n = 0;
    r = 0;
    // 64 cycles hold exactly sixteen ticks and one 16-row frame
    repeat (64) begin
      @(posedge clock);
      n += tick;
      r += frame_start;
    end
    chk("ticks", 8'h10, 8'(n));
    chk("frames", 8'h01, 8'(r));
    host.cmd2(CMD_CONTRAST, 8'h33);
    m[OFS_CONTRAST] = 8'h33;
    chk_reg(OFS_CONTRAST);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    m[OFS_CONTRAST] = 8'h7F;
    chk_reg(OFS_CONTRAST);
    final_report();
  end
endmodule // test_oled_panel_command_decoder
`default_nettype wire
